//--- frc_host_model.sv
`timescale 1ns/10ps
// stands in for the control processor on the register port
module frc_host_model (
   // clock
   input wire logic i_ref_clk,
   // register port towards the device
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_ack
);
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
   end

   // one strobe cycle; a missing ack leaves q unknown so the caller's compare fails
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      q = 8'hxx;
      @(posedge i_ref_clk);
      o_reg_wr <= wr;
      o_reg_rd <= !wr;
      o_reg_addr <= a;
      o_reg_wdata <= d;
      @(posedge i_ref_clk);
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      // released lines must not keep the old value
      o_reg_addr <= ~a;
      o_reg_wdata <= ~d;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_ref_clk);
         if (i_reg_ack === 1'b1) begin
            q = i_reg_rdata;
            break;
         end
      end
   endtask : xfer
endmodule : frc_host_model

//--- frc_pkg.sv
package frc_pkg;
   // register offsets
   localparam logic [7:0] FRC_OFS_FAULT_STATUS = 8'h10;
   localparam logic [7:0] FRC_OFS_WARN_STATUS = 8'h11;
   localparam logic [7:0] FRC_OFS_RECOVERY_CTRL = 8'h12;
   localparam logic [7:0] FRC_OFS_DENSITY_CTRL = 8'h13;
   // reset values
   localparam logic [7:0] FRC_RST_RECOVERY_CTRL = 8'h30;
   localparam logic [7:0] FRC_RST_DENSITY_CTRL = 8'h40;
   // recovery control fields
   localparam int FRC_ATTEN_LSB = 6;
   localparam int FRC_LIMIT_LSB = 4;
   localparam int FRC_MANUAL_BIT = 3;
   localparam int FRC_UV_MODE_BIT = 2;
   localparam int FRC_OT_MODE_BIT = 1;
   localparam int FRC_OC_MODE_BIT = 0;
   // density control fields
   localparam int FRC_CHAN_BIT = 7;
   localparam int FRC_PATTERN_BIT = 6;
   localparam int FRC_ADDR_PIN_BIT = 4;
   localparam int FRC_LATENCY_LSB = 2;
   localparam int FRC_SHARE_BIT = 1;
   localparam int FRC_BATTERY_BIT = 0;
   // fault status bit positions
   localparam int FRC_FLAG_BOOST_BIT = 7;
   localparam int FRC_FLAG_UV_BIT = 3;
   localparam int FRC_FLAG_OC_BIT = 2;
   localparam int FRC_FLAG_OT_BIT = 1;
   // retry limits per code, code 2'h3 means unlimited
   localparam logic [2:0] FRC_LIMIT_CODE0 = 3'h1;
   localparam logic [2:0] FRC_LIMIT_CODE1 = 3'h3;
   localparam logic [2:0] FRC_LIMIT_CODE2 = 3'h7;
   localparam logic [1:0] FRC_LIMIT_UNBOUNDED = 2'h3;
   // gain cut during heat warning in millidecibel
   localparam logic [12:0] FRC_CUT_MDB_0 = 13'h0;
   localparam logic [12:0] FRC_CUT_MDB_1 = 13'h5dc;
   localparam logic [12:0] FRC_CUT_MDB_2 = 13'hbb8;
   localparam logic [12:0] FRC_CUT_MDB_3 = 13'h15f9;
   // control bus addresses
   localparam logic [6:0] FRC_BUS_ADDR_LOW = 7'h34;
   localparam logic [6:0] FRC_BUS_ADDR_HIGH = 7'h35;
   // spacing of automatic recovery attempts
   localparam int FRC_CLK_PERIOD_NS = 25;
   localparam int FRC_RETRY_GAP_NS = 100000;
   localparam int FRC_RETRY_GAP_CYC = FRC_RETRY_GAP_NS / FRC_CLK_PERIOD_NS;
   localparam int FRC_CATEGORIES = 4;

   typedef enum logic {
      FRC_IDLE = 1'b0,
      FRC_HELD = 1'b1
   } frc_rstate_t;
endpackage : frc_pkg

//--- frc_rcv_if.sv
`timescale 1ns/10ps
interface frc_rcv_if;
   logic fault;
   logic manual_mode;
   logic manual_pulse;
   logic tick;
   logic [1:0] limit;
   logic held;
   logic retry;
   logic spent;
   modport ctrl (output fault, manual_mode, manual_pulse, tick, limit, input held, retry, spent);
   modport unit (input fault, manual_mode, manual_pulse, tick, limit, output held, retry, spent);
endinterface : frc_rcv_if

//--- frc_recover_unit.sv
`timescale 1ns/10ps
module frc_recover_unit (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // control side
   frc_rcv_if.unit bus
);
   typedef struct packed {
      frc_pkg::frc_rstate_t st;
      logic [2:0] cnt;
      logic retry;
   } frc_unit_t;

   frc_unit_t s_q;
   frc_unit_t s_d;
   logic [2:0] lim;
   logic unlimited;
   logic spent;
   logic auto_ok;
   logic man_ok;

   always_comb begin
      case (bus.limit)
         2'h0: lim = frc_pkg::FRC_LIMIT_CODE0;
         2'h1: lim = frc_pkg::FRC_LIMIT_CODE1;
         default: lim = frc_pkg::FRC_LIMIT_CODE2;
      endcase
   end

   assign unlimited = (bus.limit == frc_pkg::FRC_LIMIT_UNBOUNDED);
   assign spent = !unlimited && (s_q.cnt >= lim);
   // a spent auto category still accepts a manual request
   assign auto_ok = !bus.manual_mode && bus.tick && !spent;
   assign man_ok = bus.manual_pulse && (bus.manual_mode || spent);

   always_comb begin
      s_d = s_q;
      s_d.retry = 1'b0;
      case (s_q.st)
         frc_pkg::FRC_IDLE: begin
            if (bus.fault) begin
               s_d.st = frc_pkg::FRC_HELD;
               s_d.cnt = 3'h0;
            end
         end
         frc_pkg::FRC_HELD: begin
            if (auto_ok || man_ok) begin
               s_d.retry = 1'b1;
               if (!bus.fault) begin
                  s_d.st = frc_pkg::FRC_IDLE;
                  s_d.cnt = 3'h0;
               end else if (man_ok) begin
                  s_d.cnt = 3'h0;
               end else if (!unlimited) begin
                  s_d.cnt = s_q.cnt + 3'h1;
               end
            end
         end
         default: begin
            s_d.st = frc_pkg::FRC_IDLE;
            s_d.cnt = 3'h0;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.held = (s_q.st == frc_pkg::FRC_HELD);
   assign bus.retry = s_q.retry;
   assign bus.spent = spent;

   AST_AUTO_STOPS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (spent && !bus.manual_pulse) |=> !s_q.retry)
      else $error("automatic attempt after limit reached");
   AST_MANUAL_WAITS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (bus.manual_mode && !bus.manual_pulse) |=> !s_q.retry)
      else $error("manual category retried without request");
   AST_MANUAL_GOES: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (bus.held && bus.manual_mode && bus.manual_pulse) |=> s_q.retry)
      else $error("manual request made no attempt");
   AST_AUTO_GOES: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (bus.held && !bus.manual_mode && bus.tick && !spent) |=> s_q.retry)
      else $error("automatic attempt missed");
   COV_EXHAUST: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      bus.held && spent && bus.manual_pulse);
endmodule : frc_recover_unit

//--- frc_regs.sv
`timescale 1ns/10ps
module frc_regs #(
   parameter int P_RETRY_CYC = frc_pkg::FRC_RETRY_GAP_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_ack,
   // fault and warning detectors, booster recovery mode
   input wire logic i_heat_warning_flag,
   input wire logic i_booster_fault_flag,
   input wire logic i_undervoltage_flag,
   input wire logic i_amplifier_overcurrent_flag,
   input wire logic i_overheat_fault_flag,
   input wire logic i_booster_recover_mode,
   // pins
   input wire logic i_interface_select,
   input wire logic i_channel_address_pin,
   // recovery results, bit 0 overcurrent, 1 overheat, 2 undervoltage, 3 booster
   output logic [3:0] o_category_shutdown,
   output logic [3:0] o_category_retry,
   // audio path controls
   output logic [12:0] o_gain_cut_mdb,
   output logic o_density_channel_choice,
   output logic o_pattern_control_on,
   output logic [6:0] o_ctrl_bus_addr,
   output logic [1:0] o_latency_mode,
   output logic o_share_density_clock,
   output logic o_sense_battery
);
   typedef struct packed {
      logic [7:0] rcv;
      logic [7:0] pdm;
      logic [15:0] gap_cnt;
      logic tick;
      logic manual;
      logic [7:0] rdata;
      logic ack;
      logic [3:0] shut;
      logic [3:0] retry;
      logic [12:0] cut;
      logic chan;
      logic pat;
      logic [6:0] addr;
      logic [1:0] lat;
      logic share;
      logic batt;
   } frc_regs_t;

   frc_regs_t s_q;
   frc_regs_t s_d;
   logic [3:0] faults;
   logic [3:0] modes;
   logic [3:0] held;
   logic [3:0] retried;

   assign faults = {i_booster_fault_flag, i_undervoltage_flag, i_overheat_fault_flag,
      i_amplifier_overcurrent_flag};
   assign modes = {i_booster_recover_mode, s_q.rcv[frc_pkg::FRC_UV_MODE_BIT],
      s_q.rcv[frc_pkg::FRC_OT_MODE_BIT], s_q.rcv[frc_pkg::FRC_OC_MODE_BIT]};

   for (genvar g = 0; g < frc_pkg::FRC_CATEGORIES; g++) begin : g_cat
      frc_rcv_if u_if ();
      assign u_if.fault = faults[g];
      assign u_if.manual_mode = modes[g];
      assign u_if.manual_pulse = s_q.manual;
      assign u_if.tick = s_q.tick;
      assign u_if.limit = s_q.rcv[frc_pkg::FRC_LIMIT_LSB +: 2];
      assign held[g] = u_if.held;
      assign retried[g] = u_if.retry;
      // a category that used up its automatic budget while still faulted
      COV_SPENT: cover property (@(posedge i_ref_clk) disable iff (i_rst)
         u_if.held && u_if.spent);
      frc_recover_unit u_unit (
         .i_ref_clk(i_ref_clk),
         .i_rst(i_rst),
         .bus(u_if.unit)
      );
   end

   always_comb begin
      s_d = s_q;
      s_d.manual = 1'b0;
      s_d.ack = 1'b0;
      s_d.tick = 1'b0;
      // free-running gap between automatic attempts
      if (s_q.gap_cnt >= 16'(P_RETRY_CYC - 1)) begin
         s_d.gap_cnt = 16'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.gap_cnt = s_q.gap_cnt + 16'h1;
      end
      if (i_reg_wr) begin
         s_d.ack = 1'b1;
         case (i_reg_addr)
            frc_pkg::FRC_OFS_RECOVERY_CTRL: begin
               s_d.rcv = i_reg_wdata;
               s_d.rcv[frc_pkg::FRC_MANUAL_BIT] = 1'b0;
               s_d.manual = i_reg_wdata[frc_pkg::FRC_MANUAL_BIT];
            end
            frc_pkg::FRC_OFS_DENSITY_CTRL: s_d.pdm = i_reg_wdata;
            default: s_d.ack = 1'b1;
         endcase
      end else if (i_reg_rd) begin
         s_d.ack = 1'b1;
         s_d.rdata = 8'h0;
         case (i_reg_addr)
            frc_pkg::FRC_OFS_FAULT_STATUS: begin
               s_d.rdata[frc_pkg::FRC_FLAG_BOOST_BIT] = i_booster_fault_flag;
               s_d.rdata[frc_pkg::FRC_FLAG_UV_BIT] = i_undervoltage_flag;
               s_d.rdata[frc_pkg::FRC_FLAG_OC_BIT] = i_amplifier_overcurrent_flag;
               s_d.rdata[frc_pkg::FRC_FLAG_OT_BIT] = i_overheat_fault_flag;
            end
            frc_pkg::FRC_OFS_WARN_STATUS: s_d.rdata = {7'h0, i_heat_warning_flag};
            frc_pkg::FRC_OFS_RECOVERY_CTRL: s_d.rdata = s_q.rcv;
            frc_pkg::FRC_OFS_DENSITY_CTRL: s_d.rdata = s_q.pdm;
            default: s_d.rdata = 8'h0;
         endcase
      end
      if (!i_heat_warning_flag) begin
         s_d.cut = frc_pkg::FRC_CUT_MDB_0;
      end else begin
         case (s_q.rcv[frc_pkg::FRC_ATTEN_LSB +: 2])
            2'h0: s_d.cut = frc_pkg::FRC_CUT_MDB_0;
            2'h1: s_d.cut = frc_pkg::FRC_CUT_MDB_1;
            2'h2: s_d.cut = frc_pkg::FRC_CUT_MDB_2;
            default: s_d.cut = frc_pkg::FRC_CUT_MDB_3;
         endcase
      end
      s_d.chan = i_interface_select && s_q.pdm[frc_pkg::FRC_CHAN_BIT];
      s_d.pat = !i_interface_select && s_q.pdm[frc_pkg::FRC_PATTERN_BIT];
      // pin-chosen address applies only with the select pin low
      if (!i_interface_select && s_q.pdm[frc_pkg::FRC_ADDR_PIN_BIT] && i_channel_address_pin) begin
         s_d.addr = frc_pkg::FRC_BUS_ADDR_HIGH;
      end else begin
         s_d.addr = frc_pkg::FRC_BUS_ADDR_LOW;
      end
      s_d.lat = s_q.pdm[frc_pkg::FRC_LATENCY_LSB +: 2];
      s_d.share = s_q.pdm[frc_pkg::FRC_SHARE_BIT];
      s_d.batt = s_q.pdm[frc_pkg::FRC_BATTERY_BIT];
      s_d.shut = held;
      s_d.retry = retried;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.rcv <= frc_pkg::FRC_RST_RECOVERY_CTRL;
         s_q.pdm <= frc_pkg::FRC_RST_DENSITY_CTRL;
         s_q.addr <= frc_pkg::FRC_BUS_ADDR_LOW;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_reg_rdata = s_q.rdata;
   assign o_reg_ack = s_q.ack;
   assign o_category_shutdown = s_q.shut;
   assign o_category_retry = s_q.retry;
   assign o_gain_cut_mdb = s_q.cut;
   assign o_density_channel_choice = s_q.chan;
   assign o_pattern_control_on = s_q.pat;
   assign o_ctrl_bus_addr = s_q.addr;
   assign o_latency_mode = s_q.lat;
   assign o_share_density_clock = s_q.share;
   assign o_sense_battery = s_q.batt;

   AST_GAIN_CUT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_heat_warning_flag && s_q.rcv[7:6] == 2'h3 && !i_reg_wr) |=> o_gain_cut_mdb == 13'h15f9)
      else $error("heat warning gain cut wrong");
   AST_NO_CUT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_heat_warning_flag |=> o_gain_cut_mdb == 13'h0)
      else $error("gain cut without warning");
   AST_WARN_RSVD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h11) |=> o_reg_ack && o_reg_rdata[7:1] == 7'h0)
      else $error("reserved warning bits not zero");
   AST_MANUAL_RD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h12) |=> !o_reg_rdata[3])
      else $error("manual bit kept a one");
   AST_FLAG_RD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h10)
      |=> o_reg_rdata[1] == $past(i_overheat_fault_flag)
      && o_reg_rdata[7] == $past(i_booster_fault_flag))
      else $error("fault flag readback wrong");
   AST_CHAN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_interface_select |=> !o_density_channel_choice)
      else $error("channel choice with select pin low");
   AST_PATTERN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_interface_select |=> !o_pattern_control_on)
      else $error("pattern control with select pin high");
   AST_ADDR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!s_q.pdm[4] || i_interface_select) |=> o_ctrl_bus_addr == 7'h34)
      else $error("bus address not fixed");
   AST_PDM_FIELDS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == 8'h13) |-> ##2
      (o_share_density_clock == $past(i_reg_wdata[1], 2)
      && o_sense_battery == $past(i_reg_wdata[0], 2)
      && o_latency_mode == $past(i_reg_wdata[3:2], 2)))
      else $error("density control fields not applied");
   COV_MANUAL: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      s_q.manual && |o_category_shutdown);
   COV_ADDR_HIGH: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      o_ctrl_bus_addr == 7'h35);
   COV_CUT: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      o_gain_cut_mdb == 13'h5dc);
endmodule : frc_regs

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] flt = 4'h0;
   logic warn = 1'b0;
   logic bmode = 1'b0;
   logic sel = 1'b0;
   logic pin = 1'b0;
   logic wr, rd, ack, chan, pat, share, batt;
   logic [7:0] addr, wdata, rdata, q;
   logic [3:0] shut, retry;
   logic [12:0] cut;
   logic [6:0] baddr;
   logic [1:0] lat;
   logic [31:0] r;
   int n_fail = 0;
   int compares = 0;
   int m12 = 'h30;
   int m13 = 'h40;
   int cnt[4] = '{0, 0, 0, 0};
   int base;
   logic [12:0] cut_tab[4] = '{frc_pkg::FRC_CUT_MDB_0, frc_pkg::FRC_CUT_MDB_1,
                               frc_pkg::FRC_CUT_MDB_2, frc_pkg::FRC_CUT_MDB_3};

   always #12.5 i_ref_clk = ~i_ref_clk;

   // sampled mid-cycle so pulse counting never races the test sequence
   always @(negedge i_ref_clk) begin
      for (int c = 0; c < 4; c++) begin
         if (retry[c] === 1'b1) cnt[c]++;
      end
   end

   frc_host_model frc_host_model_i (.i_ref_clk(i_ref_clk), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_addr(addr), .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_ack(ack));

   frc_regs #(.P_RETRY_CYC(8)) frc_regs_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_ack(ack), .i_heat_warning_flag(warn),
      .i_booster_fault_flag(flt[3]), .i_undervoltage_flag(flt[2]),
      .i_amplifier_overcurrent_flag(flt[0]), .i_overheat_fault_flag(flt[1]),
      .i_booster_recover_mode(bmode), .i_interface_select(sel),
      .i_channel_address_pin(pin), .o_category_shutdown(shut), .o_category_retry(retry),
      .o_gain_cut_mdb(cut), .o_density_channel_choice(chan), .o_pattern_control_on(pat),
      .o_ctrl_bus_addr(baddr), .o_latency_mode(lat), .o_share_density_clock(share),
      .o_sense_battery(batt));

   task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (!ok) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : note

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      note(got === exp, 32'(got), 32'(exp));
   endtask : chk_reg

   task automatic chk_out(input logic [12:0] got, input logic [12:0] exp);
      note(got === exp, 32'(got), 32'(exp));
   endtask : chk_out

   task automatic chk_cnt(input int got, input int exp);
      note(got == exp, got, exp);
   endtask : chk_cnt

   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      frc_host_model_i.xfer(1'b1, a, v, q);
      // the manual request bit is never kept
      if (a == frc_pkg::FRC_OFS_RECOVERY_CTRL) m12 = v & 8'hf7;
      if (a == frc_pkg::FRC_OFS_DENSITY_CTRL) m13 = v;
   endtask : wreg

   task automatic rchk(input logic [7:0] a);
      logic [7:0] e;
      e = 8'h00;
      case (a)
         8'h10: e = {flt[3], 3'h0, flt[2], flt[0], flt[1], 1'b0};
         8'h11: e = {7'h00, warn};
         8'h12: e = 8'(m12);
         8'h13: e = 8'(m13);
         default: e = 8'h00;
      endcase
      frc_host_model_i.xfer(1'b0, a, 8'h00, q);
      chk_reg(q, e);
   endtask : rchk

   task automatic outs;
      chk_out(cut, warn ? cut_tab[m12[7:6]] : 13'h0);
      chk_out(13'(lat), 13'(m13[3:2]));
      chk_out(13'(share), 13'(m13[1]));
      chk_out(13'(batt), 13'(m13[0]));
      if (sel) begin
         chk_out(13'(chan), 13'(m13[7]));
      end else begin
         chk_out(13'(pat), 13'(m13[6]));
         chk_out(13'(baddr), (m13[4] && pin) ? 13'h35 : 13'h34);
      end
   endtask : outs

   task automatic print_verdict;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      #(25 * 20000);
      n_fail++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h5d50));
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      for (int a = 8'h10; a < 8'h14; a++) rchk(8'(a));
      rchk(8'h2a);
      outs();
      for (int k = 0; k < 8; k++) begin
         r = $urandom;
         sel <= r[8];
         pin <= r[9];
         wreg(frc_pkg::FRC_OFS_DENSITY_CTRL, r[7:0]);
         repeat (2) @(posedge i_ref_clk);
         outs();
         rchk(frc_pkg::FRC_OFS_DENSITY_CTRL);
      end
      for (int code = 0; code < 8; code++) begin
         warn <= code[0];
         wreg(frc_pkg::FRC_OFS_RECOVERY_CTRL, {code[2:1], 6'h38});
         wreg(frc_pkg::FRC_OFS_WARN_STATUS, 8'hff);
         wreg(8'h3c, 8'h5a);
         repeat (2) @(posedge i_ref_clk);
         outs();
         rchk(frc_pkg::FRC_OFS_WARN_STATUS);
         rchk(frc_pkg::FRC_OFS_RECOVERY_CTRL);
      end
      for (int k = 0; k < 4; k++) begin
         flt <= 4'($urandom);
         repeat (3) @(posedge i_ref_clk);
         rchk(frc_pkg::FRC_OFS_FAULT_STATUS);
      end
      flt <= 4'h0;
      repeat (40) @(posedge i_ref_clk);
      for (int c = 0; c < 4; c++) begin
         bmode <= (c == 3);
         wreg(frc_pkg::FRC_OFS_RECOVERY_CTRL, 8'(c << 4) | 8'((1 << c) & 7));
         flt[c] <= 1'b1;
         base = cnt[c];
         repeat (40) @(posedge i_ref_clk);
         chk_cnt(cnt[c] - base, 0);
         chk_out(13'(shut[c]), 13'h1);
         flt[c] <= 1'b0;
         base = cnt[c];
         wreg(frc_pkg::FRC_OFS_RECOVERY_CTRL, 8'(m12 | 8));
         repeat (6) @(posedge i_ref_clk);
         chk_cnt(cnt[c] - base, 1);
         chk_out(13'(shut[c]), 13'h0);
         bmode <= 1'b0;
         wreg(frc_pkg::FRC_OFS_RECOVERY_CTRL, 8'(c << 4));
         flt[c] <= 1'b1;
         base = cnt[c];
         repeat (150) @(posedge i_ref_clk);
         if (c == 3) chk_cnt(int'(cnt[c] - base > 7), 1);
         else chk_cnt(cnt[c] - base, (2 << c) - 1);
         chk_out(13'(shut[c]), 13'h1);
         flt[c] <= 1'b0;
         if (c < 3) wreg(frc_pkg::FRC_OFS_RECOVERY_CTRL, 8'(m12 | 8));
         repeat (40) @(posedge i_ref_clk);
         chk_out(13'(shut[c]), 13'h0);
      end
      print_verdict();
   end
endmodule : testbench
